// ---- hw/wws_regs.svh ----
// register offsets, field positions and timing constants of the wake/wd block
// Overview of operation
// - stop flagged wake interrupts, sleep wake resets host
// - no flag for chip-select or reset-pin wake
// - line wake needs enable, state readable
// - line muxed at entry never wakes
// - cyclic sense pulses switch, wakes on change
// - cyclic sense and forced timer exclusive
// - forced timer wakes after set period
// - stop: chip-select rising edge wakes silently
// - lin wake: long dominant then recessive
// - stop: filtered reset pin wakes silently
// - stop six sources, sleep four
// - watchdog only in normal, mode writes clear
// - early clear resets host like overflow
// - grounded config disables watchdog, sampled in reset
// - floating config uses 150 ms, flags fault
// - timing register prescales watchdog timebase
// - normal request 150 ms timeout resets
// - switch follows on bit, gated by pwm
// - open-load and current-limit reported per switch
// - overtemp: both off, event, all bits set
// - overvoltage cut, rewrite control to restore
// - mode reg: cut, pull-up, two op bits
// - wake reg: line enable in bit 0
// - switch reg: gates two/one, on two/one
`ifndef WWS_REGS_SVH
`define WWS_REGS_SVH

// write addresses on the link
`define WWS_ADDR_MODE 4'h0
`define WWS_ADDR_WAKE 4'h2
`define WWS_ADDR_SWITCH 4'h6
`define WWS_ADDR_TIMING 4'h9
`define WWS_ADDR_IMASK 4'hE

// mode control field
`define WWS_MODE_OVCUT 3
`define WWS_MODE_LINPU 2
`define WWS_MODE_OP_HI 1
`define WWS_MODE_OP_LO 0
`define WWS_OP_STOP 2'h1
`define WWS_OP_SLEEP 2'h2
// wake control / switch control / timing / mask fields
`define WWS_WAKE_LINE_EN 0
`define WWS_SW_GATE_TWO 3
`define WWS_SW_GATE_ONE 2
`define WWS_SW_ON_TWO 1
`define WWS_SW_ON_ONE 0
`define WWS_TIM_PERIOD_SEL 3
`define WWS_IMASK_SWITCH 0

// reset values
`define WWS_RST_NIBBLE 4'h0
`define WWS_RST_LEN 3'h0

// times and derived cycle counts at 25 MHz
`define WWS_CLK_MHZ 25
`define WWS_LIN_FILT_US 100
`define WWS_LIN_FILT_CYC (`WWS_LIN_FILT_US * `WWS_CLK_MHZ)
`define WWS_RST_GLITCH_US 10
`define WWS_RST_GLITCH_CYC (`WWS_RST_GLITCH_US * `WWS_CLK_MHZ)
`define WWS_FALLBACK_MS 150
`define WWS_NREQ_MS 150
`define WWS_RST_HOLD_MS 1
`define WWS_SENSE_MS 1

`endif

// ---- hw/wws_pkg.sv ----
// types shared by the wake, watchdog and switch control block
package wws_pkg;
  typedef enum logic [4:0] {
    WWS_RESET  = 5'b0_0001,
    WWS_NREQ   = 5'b0_0010,
    WWS_NORMAL = 5'b0_0100,
    WWS_STOP   = 5'b0_1000,
    WWS_SLEEP  = 5'b1_0000
  } wws_mode_t;
endpackage

// ---- hw/wws_ctrl.sv ----
// wake-up, window watchdog and high-side switch control
`timescale 1ns/100ps
`default_nettype none
`include "wws_regs.svh"
module wws_ctrl #(
  parameter int MS_CYC = 25000,
  parameter int WD_RES_MS = 100,
  parameter int CYC_UNIT_MS = 10
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic spi_clk_in,
  input wire logic spi_wr_in,
  input wire logic [3:0] spi_addr_in,
  input wire logic [3:0] spi_data_in,
  input wire logic irq_ack_in,
  input wire logic wake_input_line_in,
  input wire logic cs_n_in,
  input wire logic lin_rx_in,
  input wire logic rst_pin_n_in,
  input wire logic pulse_input_pin_in,
  input wire logic cfg_gnd_in,
  input wire logic cfg_res_in,
  input wire logic mux_wake_sel_in,
  input wire logic overtemp_in,
  input wire logic overvolt_in,
  input wire logic [1:0] open_load_in,
  input wire logic [1:0] current_limit_in,
  output logic [1:0] high_side_switch_out,
  output logic [1:0] open_load_out,
  output logic [1:0] current_limit_out,
  output wws_pkg::wws_mode_t mode_out,
  output logic host_rst_n_out,
  output logic irq_n_out,
  output logic regulator_on_out,
  output logic lin_pullup_enable_out,
  output logic wake_line_state_out,
  output logic [2:0] wake_src_out,
  output logic switch_event_out,
  output logic watchdog_off_flag_out,
  output logic watchdog_fault_out
);
  import wws_pkg::*;

  // link-side write capture; rst level synchronised into this domain
  logic spi_rs1_q, spi_rs2_q, wr_tog_q;
  logic [3:0] hold_addr_q, hold_data_q;
  always_ff @(posedge spi_clk_in) begin
    spi_rs1_q <= srst_in;
    spi_rs2_q <= spi_rs1_q;
  end
  always_ff @(posedge spi_clk_in) begin
    if (spi_rs2_q) begin
      wr_tog_q <= 1'b0;
      hold_addr_q <= `WWS_RST_NIBBLE;
      hold_data_q <= `WWS_RST_NIBBLE;
    end else if (spi_wr_in) begin
      wr_tog_q <= ~wr_tog_q;
      hold_addr_q <= spi_addr_in;
      hold_data_q <= spi_data_in;
    end
  end

  // toggle crossing; hold words are stable long before the toggle lands
  logic tog_s1_q, tog_s2_q, tog_s3_q, wr_stb;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= wr_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end
  assign wr_stb = tog_s2_q ^ tog_s3_q;

  // two-flop synchronisers for every pin
  localparam int NP = 14;
  logic [NP-1:0] pin_raw, pin_s1_q, pin_s2_q;
  assign pin_raw = {wake_input_line_in, cs_n_in, lin_rx_in, rst_pin_n_in,
                    pulse_input_pin_in, cfg_gnd_in, cfg_res_in,
                    mux_wake_sel_in, overtemp_in, overvolt_in,
                    open_load_in, current_limit_in};
  always_ff @(posedge clk_in) begin
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
  end
  logic line_s, cs_s, lin_s, rstp_s, pwm_s, gnd_s, res_s, mux_s, ot_s, ov_s;
  logic [1:0] ol_s, cl_s;
  assign {line_s, cs_s, lin_s, rstp_s, pwm_s, gnd_s, res_s, mux_s, ot_s,
          ov_s, ol_s, cl_s} = pin_s2_q;

  // register fields written over the link
  logic [3:0] mode_reg_q, switch_reg_q;
  logic line_en_q, period_sel_q, sw_mask_q;
  logic [2:0] period_len_q, wd_presc_q;
  logic mode_wr, switch_wr;
  assign mode_wr = wr_stb && hold_addr_q == `WWS_ADDR_MODE;
  assign switch_wr = wr_stb && hold_addr_q == `WWS_ADDR_SWITCH;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_reg_q <= `WWS_RST_NIBBLE;
      switch_reg_q <= `WWS_RST_NIBBLE;
      line_en_q <= 1'b0;
      period_sel_q <= 1'b0;
      period_len_q <= `WWS_RST_LEN;
      wd_presc_q <= `WWS_RST_LEN;
      sw_mask_q <= 1'b0;
    end else if (wr_stb) begin
      unique case (hold_addr_q)
        `WWS_ADDR_MODE: mode_reg_q <= hold_data_q;
        `WWS_ADDR_WAKE: line_en_q <= hold_data_q[`WWS_WAKE_LINE_EN];
        `WWS_ADDR_SWITCH: switch_reg_q <= hold_data_q;
        `WWS_ADDR_TIMING: begin
          // select bit steers period or prescaler
          if (hold_data_q[`WWS_TIM_PERIOD_SEL]) begin
            period_sel_q <= 1'b1;
            period_len_q <= hold_data_q[2:0];
          end else begin
            wd_presc_q <= hold_data_q[2:0];
          end
        end
        `WWS_ADDR_IMASK: sw_mask_q <= hold_data_q[`WWS_IMASK_SWITCH];
        default: ;
      endcase
    end
  end

  // millisecond tick shared by all slow timers
  logic [15:0] ms_cnt_q;
  logic ms_tick;
  assign ms_tick = ms_cnt_q == 16'(MS_CYC - 1);
  always_ff @(posedge clk_in) begin
    if (srst_in || ms_tick) begin
      ms_cnt_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 16'h0001;
    end
  end

  // reset-pin glitch filter; the match lasts one cycle so that a pin held
  // low acts once and a stop wake is not undone into reset mode
  logic [8:0] rglt_q;
  logic rst_pin_low;
  assign rst_pin_low = rglt_q == 9'(`WWS_RST_GLITCH_CYC);
  always_ff @(posedge clk_in) begin
    if (srst_in || rstp_s) begin
      rglt_q <= 9'h000;
    end else if (rglt_q <= 9'(`WWS_RST_GLITCH_CYC)) begin
      rglt_q <= rglt_q + 9'h001;
    end
  end

  // edge helpers read only the second sync stage
  logic cs_d_q, lin_d_q;
  always_ff @(posedge clk_in) begin
    cs_d_q <= cs_s;
    lin_d_q <= lin_s;
  end

  wws_mode_t mode_q;
  logic lowpwr;
  assign lowpwr = mode_q == WWS_STOP || mode_q == WWS_SLEEP;

  // dominant (low) must outlast the filter before release counts
  logic [11:0] lin_cnt_q;
  logic lin_armed, lin_wake;
  assign lin_armed = lin_cnt_q == 12'(`WWS_LIN_FILT_CYC);
  assign lin_wake = lowpwr && lin_armed && lin_s && !lin_d_q;
  always_ff @(posedge clk_in) begin
    if (srst_in || !lowpwr || lin_s) begin
      lin_cnt_q <= 12'h000;
    end else if (!lin_armed) begin
      lin_cnt_q <= lin_cnt_q + 12'h001;
    end
  end

  // entry snapshot: line reference, mux lock, timer use
  logic line_ref_q, mux_lock_q, cyc_q, forced_q;
  logic enter_lp;
  assign enter_lp = mode_wr && mode_q == WWS_NORMAL &&
    (hold_data_q[1:0] == `WWS_OP_STOP || hold_data_q[1:0] == `WWS_OP_SLEEP);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      line_ref_q <= 1'b0;
      mux_lock_q <= 1'b0;
      cyc_q <= 1'b0;
      forced_q <= 1'b0;
    end else if (enter_lp) begin
      line_ref_q <= line_s;
      // line muxed at entry loses wake ability
      mux_lock_q <= mux_s;
      // switch enable decides: cyclic xor forced
      cyc_q <= period_sel_q && line_en_q && |switch_reg_q[1:0];
      forced_q <= period_sel_q && ~|switch_reg_q[1:0];
    end
  end

  // low-power period timer and one-ms sense pulse
  logic [23:0] lp_cnt_q, lp_period;
  logic sense_q, period_end, sense_end;
  assign lp_period = 24'(CYC_UNIT_MS) << period_len_q;
  assign period_end = ms_tick && lp_cnt_q == lp_period - 24'h00_0001;
  assign sense_end = sense_q && ms_tick;
  always_ff @(posedge clk_in) begin
    if (srst_in || !lowpwr || period_end) begin
      lp_cnt_q <= 24'h00_0000;
    end else if (ms_tick) begin
      lp_cnt_q <= lp_cnt_q + 24'h00_0001;
    end
  end
  // switch pulsed at each period end when cyclic sense is on
  always_ff @(posedge clk_in) begin
    if (srst_in || !lowpwr) begin
      sense_q <= 1'b0;
    end else if (period_end && cyc_q) begin
      sense_q <= 1'b1;
    end else if (sense_end) begin
      sense_q <= 1'b0;
    end
  end

  // wake sources
  logic line_wake, cyc_wake, frc_wake, cs_wake, rst_wake, any_wake, flag_wake;
  // direct line wake only when enabled
  assign line_wake = lowpwr && line_en_q && !mux_lock_q && !cyc_q &&
    line_s != line_ref_q;
  assign cyc_wake = lowpwr && cyc_q && !mux_lock_q && sense_end &&
    line_s != line_ref_q;
  assign frc_wake = lowpwr && forced_q && period_end;
  // rising chip select in stop only
  assign cs_wake = mode_q == WWS_STOP && cs_s && !cs_d_q;
  // filtered reset pin in stop only
  assign rst_wake = mode_q == WWS_STOP && rst_pin_low;
  // sleep ignores chip select and reset pin
  assign flag_wake = line_wake || cyc_wake || frc_wake || lin_wake;
  assign any_wake = flag_wake || cs_wake || rst_wake;

  // watchdog configuration, caught only while in reset mode
  logic wd_off_q, wd_fault_q;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wd_off_q <= 1'b0;
      wd_fault_q <= 1'b0;
    end else if (mode_q == WWS_RESET) begin
      wd_off_q <= gnd_s;
      wd_fault_q <= !gnd_s && !res_s;
    end
  end

  // watchdog window; period in ms after prescaling
  logic [23:0] wd_cnt_q, wd_period, mode_ms_q;
  logic wd_run, wd_clear, wd_early, wd_over, wd_fail;
  assign wd_period = (wd_fault_q ? 24'(`WWS_FALLBACK_MS) : 24'(WD_RES_MS))
    << wd_presc_q;
  assign wd_run = mode_q == WWS_NORMAL && !wd_off_q;
  assign wd_clear = wd_run && mode_wr &&
    hold_data_q[1:0] != `WWS_OP_STOP && hold_data_q[1:0] != `WWS_OP_SLEEP;
  assign wd_early = wd_clear && wd_cnt_q < (wd_period >> 1);
  assign wd_over = wd_run && ms_tick && wd_cnt_q == wd_period - 24'h00_0001;
  assign wd_fail = wd_early || wd_over;
  always_ff @(posedge clk_in) begin
    if (srst_in || !wd_run || wd_clear) begin
      wd_cnt_q <= 24'h00_0000;
    end else if (ms_tick) begin
      wd_cnt_q <= wd_cnt_q + 24'h00_0001;
    end
  end

  // per-mode ms timer: reset hold and normal-request timeout; it is only
  // trusted once mode_out has caught up, else a stale count leaks across
  logic mode_settled;
  assign mode_settled = mode_out == mode_q;
  always_ff @(posedge clk_in) begin
    if (srst_in || !mode_settled) begin
      mode_ms_q <= 24'h00_0000;
    end else if (ms_tick) begin
      mode_ms_q <= mode_ms_q + 24'h00_0001;
    end
  end

  // operating mode sequencer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_q <= WWS_RESET;
    end else begin
      unique case (mode_q)
        WWS_RESET: begin
          if (rstp_s && mode_settled &&
              mode_ms_q >= 24'(`WWS_RST_HOLD_MS)) begin
            mode_q <= gnd_s ? WWS_NORMAL : WWS_NREQ;
          end
        end
        WWS_NREQ: begin
          // leave within 150 ms or reset
          if (rst_pin_low ||
              (mode_settled && mode_ms_q >= 24'(`WWS_NREQ_MS))) begin
            mode_q <= WWS_RESET;
          end else if (mode_wr) begin
            mode_q <= WWS_NORMAL;
          end
        end
        WWS_NORMAL: begin
          if (rst_pin_low || wd_fail) begin
            mode_q <= WWS_RESET;
          end else if (enter_lp) begin
            mode_q <= hold_data_q[1:0] == `WWS_OP_STOP ? WWS_STOP : WWS_SLEEP;
          end
        end
        WWS_STOP: begin
          // config decides target of reset-pin wake
          // watchdog off also removes normal request for every wake
          if (any_wake) begin
            mode_q <= wd_off_q ? WWS_NORMAL : WWS_NREQ;
          end
        end
        WWS_SLEEP: begin
          // sleep wake goes through host reset
          if (flag_wake) begin
            mode_q <= WWS_RESET;
          end
        end
      endcase
    end
  end

  logic [2:0] wake_src_q;
  always_ff @(posedge clk_in) begin
    if (srst_in || (irq_ack_in && !flag_wake)) begin
      wake_src_q <= 3'h0;
    end else if (flag_wake) begin
      wake_src_q <= wake_src_q | {lin_wake, cyc_wake || frc_wake, line_wake};
    end
  end

  // switch shutdown latch; set beats a clearing write
  logic shut_ot_q, shut_ov_q, sw_event_q;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      shut_ot_q <= 1'b0;
      shut_ov_q <= 1'b0;
    end else begin
      shut_ot_q <= ot_s || (shut_ot_q && !switch_wr);
      shut_ov_q <= (ov_s && mode_reg_q[`WWS_MODE_OVCUT]) ||
        (shut_ov_q && !switch_wr);
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sw_event_q <= 1'b0;
    end else if (ot_s) begin
      sw_event_q <= 1'b1;
    end else if (irq_ack_in) begin
      sw_event_q <= 1'b0;
    end
  end

  logic [1:0] sw_drive;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sw
      assign sw_drive[g] = !shut_ot_q && !shut_ov_q && (lowpwr ? (sense_q &&
        switch_reg_q[g]) : (mode_q != WWS_RESET && switch_reg_q[g] &&
        (!switch_reg_q[g + 2] || pwm_s)));
    end
  endgenerate

  // interrupt: flagged stop-mode wake or masked switch event
  logic irq_q, irq_set;
  // of the wakes, only stop mode ones raise the line
  assign irq_set = (mode_q == WWS_STOP && flag_wake) ||
    (ot_s && sw_mask_q && mode_q != WWS_RESET && mode_q != WWS_SLEEP);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_q <= 1'b0;
    end else if (irq_set) begin
      irq_q <= 1'b1;
    end else if (irq_ack_in) begin
      irq_q <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      high_side_switch_out <= 2'h0;
      open_load_out <= 2'h0;
      current_limit_out <= 2'h0;
      mode_out <= WWS_RESET;
      host_rst_n_out <= 1'b0;
      irq_n_out <= 1'b1;
      regulator_on_out <= 1'b1;
      lin_pullup_enable_out <= 1'b0;
      wake_line_state_out <= 1'b0;
      wake_src_out <= 3'h0;
      switch_event_out <= 1'b0;
      watchdog_off_flag_out <= 1'b0;
      watchdog_fault_out <= 1'b0;
    end else begin
      high_side_switch_out <= sw_drive;
      open_load_out <= shut_ot_q ? 2'h3 : ol_s;
      current_limit_out <= shut_ot_q ? 2'h3 : cl_s;
      mode_out <= mode_q;
      host_rst_n_out <= mode_q != WWS_RESET;
      irq_n_out <= !irq_q;
      regulator_on_out <= mode_q != WWS_SLEEP;
      lin_pullup_enable_out <= mode_reg_q[`WWS_MODE_LINPU];
      wake_line_state_out <= line_s;
      wake_src_out <= wake_src_q;
      switch_event_out <= sw_event_q;
      watchdog_off_flag_out <= wd_off_q;
      watchdog_fault_out <= wd_fault_q;
    end
  end
endmodule
`default_nettype wire

// ---- tb/wws_ctrl_sva.sv ----
// concurrent checks on the ports of the wake, watchdog and switch block
`timescale 1ns/100ps
`default_nettype none
module wws_ctrl_sva (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic wake_input_line_in,
  input wire logic lin_rx_in,
  input wire logic overtemp_in,
  input wire logic [1:0] high_side_switch_out,
  input wire wws_pkg::wws_mode_t mode_out,
  input wire logic host_rst_n_out,
  input wire logic irq_n_out,
  input wire logic regulator_on_out,
  input wire logic wake_line_state_out,
  input wire logic [2:0] wake_src_out
);
  import wws_pkg::*;
  // one clock domain here, so clocking and reset are given once
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  AST_OT_OFF: assert property (
    overtemp_in [*5] |-> high_side_switch_out == 2'h0)
    else $error("switch on during overtemperature");
  AST_SLEEP_REG: assert property (
    mode_out == WWS_SLEEP && $past(mode_out) == WWS_SLEEP
    |-> !regulator_on_out)
    else $error("regulator on in sleep");
  AST_SLEEP_EXIT: assert property (
    mode_out == WWS_SLEEP ##1 mode_out != WWS_SLEEP
    |-> mode_out == WWS_RESET)
    else $error("sleep left without reset");
  AST_STOP_EXIT: assert property (
    mode_out == WWS_STOP ##1 mode_out != WWS_STOP
    |-> mode_out inside {WWS_NREQ, WWS_NORMAL})
    else $error("stop left to a wrong mode");
  AST_SLEEP_SRC: assert property (
    mode_out == WWS_SLEEP ##1 mode_out == WWS_RESET
    |-> ##[0:2] wake_src_out != 3'h0)
    else $error("sleep wake without a source flag");
  AST_HOST_RST: assert property (
    mode_out == WWS_RESET && $past(mode_out) == WWS_RESET
    |-> !host_rst_n_out)
    else $error("host released in reset mode");
  AST_LINE_STATE: assert property (
    $stable(wake_input_line_in) [*5]
    |-> wake_line_state_out == wake_input_line_in)
    else $error("wake line state wrong");
  AST_LIN_HOLD: assert property (
    (mode_out == WWS_SLEEP && !lin_rx_in) [*6] |-> ##1 mode_out == WWS_SLEEP)
    else $error("woke while bus still dominant");
  // main scenarios reached
  COV_STOP_WAKE: cover property (mode_out == WWS_STOP ##1 mode_out == WWS_NREQ);
  COV_SLEEP_WAKE: cover property (
    mode_out == WWS_SLEEP ##1 mode_out == WWS_RESET);
  COV_IRQ: cover property ($fell(irq_n_out));
endmodule
`default_nettype wire

// ---- tb/wws_host_model.sv ----
// host model: link writes on a gated link clock and interrupt acknowledge
`timescale 1ns/100ps
`default_nettype none
module wws_host_model (
  input wire logic clk_in,
  input wire logic hold_in,
  output logic spi_clk_out,
  output logic spi_wr_out,
  output logic [3:0] spi_addr_out,
  output logic [3:0] spi_data_out,
  output logic irq_ack_out
);
  logic busy = 1'h0;
  // link clock runs only in a frame or while held, off-phase to the core
  initial begin
    spi_clk_out = 1'h0;
    spi_wr_out = 1'h0;
    spi_addr_out = 4'hF;
    spi_data_out = 4'hF;
    irq_ack_out = 1'h0;
    #13;
    forever #40 if (hold_in || busy || spi_clk_out) spi_clk_out = ~spi_clk_out;
  end
  // host setup writes
  // released lines show the inverse, so stale values cannot pass
  task automatic wr(input logic [3:0] addr, input logic [3:0] data);
    busy = 1'h1;
    @(negedge spi_clk_out);
    spi_wr_out = 1'h1;
    spi_addr_out = addr;
    spi_data_out = data;
    @(posedge spi_clk_out);
    spi_wr_out <= 1'h0;
    spi_addr_out <= ~addr;
    spi_data_out <= ~data;
    repeat (3) @(posedge spi_clk_out);
    busy = 1'h0;
  endtask
  // one core-cycle acknowledge pulse
  task automatic ack();
    @(negedge clk_in);
    irq_ack_out = 1'h1;
    @(negedge clk_in);
    irq_ack_out = 1'h0;
  endtask
endmodule
`default_nettype wire

// ---- tb/wws_ctrl_test.sv ----
// self-checking bench of the wake, watchdog and switch control block
`timescale 1ns/100ps
`default_nettype none
module wws_ctrl_test;
  import wws_pkg::*;
  typedef struct packed {
    logic [3:0] ctl;
    logic pwm;
    logic [1:0] diag;
    logic [1:0] sw;
  } wws_row_t;
  // switch control word, pwm pin, diagnostics in and expected drive
  wws_row_t rows [9] = '{'{4'h1, 1'h0, 2'h1, 2'h1}, '{4'h2, 1'h0, 2'h2, 2'h2},
    '{4'h3, 1'h0, 2'h0, 2'h3}, '{4'h7, 1'h0, 2'h1, 2'h2},
    '{4'h7, 1'h1, 2'h2, 2'h3}, '{4'hF, 1'h0, 2'h0, 2'h0},
    '{4'hF, 1'h1, 2'h3, 2'h3}, '{4'hB, 1'h0, 2'h1, 2'h1},
    '{4'h0, 1'h1, 2'h0, 2'h0}};
  logic clk_in = 1'h0, srst_in = 1'h1, link_hold = 1'h1;
  logic wake_line = 1'h0, cs_n = 1'h1, lin_rx = 1'h1, rst_pin_n = 1'h1;
  logic pwm = 1'h0, cfg_gnd = 1'h0, cfg_res = 1'h1, mux_sel = 1'h0;
  logic overtemp = 1'h0, overvolt = 1'h0;
  logic [1:0] ol_in = 2'h0, cl_in = 2'h0, sw_out, ol_out, cl_out;
  logic spi_clk, spi_wr, irq_ack, host_rst_n, irq_n, reg_on, lin_pu;
  logic line_state, sw_event, wd_off, wd_fault;
  logic [3:0] spi_addr, spi_data;
  logic [2:0] wake_src;
  wws_mode_t mode_out;
  int error_cnt = 0, comparisons = 0, cycles = 0, n;
  // 25 MHz core clock
  always #20 clk_in = ~clk_in;
  // ms scaled to 50 cycles and cyclic unit to 2 ms to keep the run short
  wws_ctrl #(.MS_CYC(50), .CYC_UNIT_MS(2)) wws_ctrl_i (.clk_in(clk_in),
    .srst_in(srst_in), .spi_clk_in(spi_clk), .spi_wr_in(spi_wr),
    .spi_addr_in(spi_addr), .spi_data_in(spi_data), .irq_ack_in(irq_ack),
    .wake_input_line_in(wake_line), .cs_n_in(cs_n), .lin_rx_in(lin_rx),
    .rst_pin_n_in(rst_pin_n), .pulse_input_pin_in(pwm),
    .cfg_gnd_in(cfg_gnd), .cfg_res_in(cfg_res), .mux_wake_sel_in(mux_sel),
    .overtemp_in(overtemp), .overvolt_in(overvolt), .open_load_in(ol_in),
    .current_limit_in(cl_in), .high_side_switch_out(sw_out),
    .open_load_out(ol_out), .current_limit_out(cl_out), .mode_out(mode_out),
    .host_rst_n_out(host_rst_n), .irq_n_out(irq_n),
    .regulator_on_out(reg_on), .lin_pullup_enable_out(lin_pu),
    .wake_line_state_out(line_state), .wake_src_out(wake_src),
    .switch_event_out(sw_event), .watchdog_off_flag_out(wd_off),
    .watchdog_fault_out(wd_fault));
  wws_host_model wws_host_model_i (.clk_in(clk_in), .hold_in(link_hold),
    .spi_clk_out(spi_clk), .spi_wr_out(spi_wr), .spi_addr_out(spi_addr),
    .spi_data_out(spi_data), .irq_ack_out(irq_ack));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  task automatic wait_mode(input wws_mode_t m, input int k);
    for (int i = 0; i < k && mode_out !== m; i++) @(negedge clk_in);
    check(mode_out, m);
  endtask
  task automatic go(input logic [3:0] d, input wws_mode_t m);
    wws_host_model_i.wr(4'h0, d);
    wait_mode(m, 20);
  endtask
  // link clock must run while the link side comes out of reset
  task automatic reset_dut();
    srst_in = 1'h1;
    link_hold = 1'h1;
    cyc(20);
    srst_in = 1'h0;
    cyc(8);
    link_hold = 1'h0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard: the whole run needs roughly 18k cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      $display("[ERR] %0t run did not finish", $time);
      stop_test();
    end
  end
  initial begin
    reset_dut();
    check({mode_out, host_rst_n, irq_n, reg_on}, {WWS_RESET, 3'h3});
    check(sw_out, 2'h0);
    wait_mode(WWS_NREQ, 300);
    check({host_rst_n, wd_off, wd_fault}, 3'h4);
    go(4'hC, WWS_NORMAL);
    check(lin_pu, 1'h1);
    $display("reset and mode test done");
    foreach (rows[i]) begin
      pwm = rows[i].pwm;
      ol_in = rows[i].diag;
      cl_in = ~rows[i].diag;
      wws_host_model_i.wr(4'h6, rows[i].ctl);
      cyc(8);
      check(sw_out, rows[i].sw);
      check({ol_out, cl_out}, {rows[i].diag, ~rows[i].diag});
    end
    $display("switch table test done");
    wws_host_model_i.wr(4'hE, 4'h1);
    wws_host_model_i.wr(4'h6, 4'h3);
    overtemp = 1'h1;
    cyc(6);
    check({sw_out, ol_out, cl_out, sw_event, irq_n}, 8'h3E);
    overtemp = 1'h0;
    cyc(6);
    check(sw_out, 2'h0);
    wws_host_model_i.wr(4'h6, 4'h3);
    cyc(8);
    check(sw_out, 2'h3);
    wws_host_model_i.ack();
    cyc(3);
    check({sw_event, irq_n}, 2'h1);
    overvolt = 1'h1;
    cyc(6);
    check(sw_out, 2'h0);
    overvolt = 1'h0;
    wws_host_model_i.wr(4'h6, 4'h0);
    $display("shutdown test done");
    go(4'hC, WWS_RESET);
    check(host_rst_n, 1'h0);
    wait_mode(WWS_NREQ, 300);
    for (n = 0; mode_out === WWS_NREQ && n < 8000; n++) @(negedge clk_in);
    check(n >= 149 * 50 && n <= 151 * 50, 1'h1);
    wait_mode(WWS_NREQ, 300);
    go(4'hC, WWS_NORMAL);
    cyc(3000);
    wws_host_model_i.wr(4'h0, 4'hC);
    cyc(3000);
    check(mode_out, WWS_NORMAL);
    $display("watchdog test done");
    wws_host_model_i.wr(4'h2, 4'h1);
    go(4'hD, WWS_STOP);
    wake_line = 1'h1;
    wait_mode(WWS_NREQ, 40);
    check({irq_n, wake_src}, 4'h1);
    wws_host_model_i.ack();
    go(4'hC, WWS_NORMAL);
    go(4'hD, WWS_STOP);
    cs_n = 1'h0;
    cyc(4);
    cs_n = 1'h1;
    wait_mode(WWS_NREQ, 20);
    check({irq_n, wake_src}, 4'h8);
    go(4'hC, WWS_NORMAL);
    mux_sel = 1'h1;
    go(4'hD, WWS_STOP);
    wake_line = 1'h0;
    cyc(100);
    check(mode_out, WWS_STOP);
    rst_pin_n = 1'h0;
    cyc(300);
    rst_pin_n = 1'h1;
    mux_sel = 1'h0;
    wait_mode(WWS_NREQ, 400);
    check({irq_n, wake_src}, 4'h8);
    $display("stop wake test done");
    go(4'hC, WWS_NORMAL);
    go(4'hE, WWS_SLEEP);
    check(reg_on, 1'h0);
    lin_rx = 1'h0;
    cyc(100);
    lin_rx = 1'h1;
    cyc(20);
    check(mode_out, WWS_SLEEP);
    lin_rx = 1'h0;
    cyc(2600);
    lin_rx = 1'h1;
    wait_mode(WWS_RESET, 20);
    check({irq_n, wake_src}, 4'hC);
    wait_mode(WWS_NREQ, 300);
    check(reg_on, 1'h1);
    wws_host_model_i.ack();
    go(4'hC, WWS_NORMAL);
    wws_host_model_i.wr(4'h9, 4'h8);
    go(4'hD, WWS_STOP);
    cyc(50);
    check(mode_out, WWS_STOP);
    wait_mode(WWS_NREQ, 300);
    check({irq_n, wake_src}, 4'h2);
    wws_host_model_i.ack();
    go(4'hC, WWS_NORMAL);
    wws_host_model_i.wr(4'h6, 4'h1);
    go(4'hD, WWS_STOP);
    wake_line = 1'h1;
    cyc(40);
    check(mode_out, WWS_STOP);
    for (n = 0; sw_out !== 2'h1 && n < 150; n++) @(negedge clk_in);
    check({mode_out, sw_out}, {WWS_STOP, 2'h1});
    wait_mode(WWS_NREQ, 80);
    check({irq_n, wake_src}, 4'h2);
    $display("low power wake test done");
    cfg_gnd = 1'h1;
    reset_dut();
    wait_mode(WWS_NORMAL, 300);
    check(wd_off, 1'h1);
    cfg_gnd = 1'h0;
    cfg_res = 1'h0;
    reset_dut();
    wait_mode(WWS_NREQ, 300);
    check({wd_off, wd_fault}, 2'h1);
    $display("config pin test done");
    stop_test();
  end
endmodule
bind wws_ctrl wws_ctrl_sva wws_ctrl_sva_i (.*);
`default_nettype wire
